// file: pager_if_pkg.sv
// constants, types and helpers shared by the pager decoder host interface
package pager_if_pkg;

  // ************************************************************
  // register map and control/status field positions
  // ************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h1e;
  localparam logic [7:0] DATA_ADDR = 8'h1f;
  localparam int BIT_ON = 0;
  localparam int BIT_RES = 1;
  localparam int BIT_CT = 2;
  localparam int BIT_STB = 3;
  localparam int BIT_BF = 4;
  localparam int BIT_OR = 5;
  localparam int BIT_BL = 6;
  localparam int BIT_DR = 7;
  localparam int BIT_ERR = 7;

  // ************************************************************
  // word formats and block sizes
  // ************************************************************
  localparam logic [7:0] TERM_WORD = 8'h04;
  localparam int ACC_W = 27;
  localparam int CNT_W = 5;
  localparam int MSG_BITS = 20;
  localparam logic [4:0] BLK_ALPHA = 5'h7;
  localparam logic [4:0] BLK_NUM = 5'h4;
  localparam logic [4:0] MSG_CNT = 5'h14;
  localparam logic [1:0] FUNC_NUMERIC = 2'h0;

  // ************************************************************
  // timing: word pacing and out-of-range hold unit
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WORD_GAP_US = 2000;
  localparam int RANGE_UNIT_US = 1000;
  localparam int WORD_GAP_CYC = WORD_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int RANGE_UNIT_CYC = RANGE_UNIT_US * 1000 / CLK_PERIOD_NS;

  // kinds of codeword event offered by the decoder core
  typedef enum logic [1:0] {
    CW_ADDR, CW_MSG, CW_END_OK, CW_END_FAIL
  } cw_kind_t;

  // four-bit numeric code to seven-bit character
  function automatic logic [6:0] num_to_char(logic [3:0] n);
    unique case (n)
      4'ha: num_to_char = 7'h2a;
      4'hb: num_to_char = 7'h55;
      4'hc: num_to_char = 7'h20;
      4'hd: num_to_char = 7'h2d;
      4'he: num_to_char = 7'h5d;
      4'hf: num_to_char = 7'h5b;
      default: num_to_char = {3'h3, n};
    endcase
  endfunction

endpackage

// file: pager_decoder_host_interface.sv
// decoder host interface: call word formatter, fifo and status byte
`timescale 1ns/1ps

// Overview of operation
// RQ1: control bit 0 written 0 runs the decoder, 1 puts it in standby.
// RQ2: software pulses core clear bit 1 low then high after power up.
// RQ3: status bit 2 is 1 during message reception, 0 once the call ends.
// RQ4: status bit 3 shows standby, entered whenever the standby select is 1.
// RQ5: status bit 4 follows the power fail pin, not latched.
// RQ6: status bit 5 drops low only after the selected range hold expires.
// RQ7: bit 5 goes high on valid data, on standby, and while not enabled.
// RQ8: decoder clears bit 6 on supply low; software writes it back to 1.
// RQ9: bit 7 clears when a word lands in the data byte; software resets it.
// RQ10: writes cannot alter call, standby, power fail or range flags.
// RQ11: a call gives the address word first, then message words.
// RQ12: all call data is delivered as 8-bit words through the data byte.
// RQ13: the ready flag falls in the same cycle the word appears.
// RQ14: software must read each word before the next one overwrites it.
// RQ15: good call end emits termination byte: error flag, bit 2 set.
// RQ16: loss of sync ends the call as unsuccessful.
// RQ17: conversion off means numeric; on, function 00 numeric else alpha.
// RQ18: alpha mode cuts message bits into 7-bit blocks plus error flag.
// RQ19: numeric mode cuts 4-bit blocks translated to 7-bit characters.
// RQ20: nibble packing puts raw 4-bit block in bits 3..0, zeros above; the code puts the error flag in bit 7, zeros in bits 6..4.
// RQ21: digits 0..9 map to ASCII digits, six codes to fixed symbols.
// RQ22: error flag marks codewords still in error after correction.
// RQ23: address word: sync fail, user index, duplicate, zero, function.
// RQ24: reading the data byte changes no flag.

// ************************************************************
// word fifo
// ************************************************************
module call_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] count;
  } fifo_state_t;

  fifo_state_t q, d;
  logic push, pop;

  function automatic logic [PW-1:0] bump(logic [PW-1:0] p);
    bump = (p == LAST) ? '0 : PW'(p + 1'b1);
  endfunction

  // full and empty come straight from the occupancy count
  assign inReady = (q.count != (PW + 1)'(DEPTH));
  assign outValid = (q.count != '0);
  assign outData = q.mem[q.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // next state: write, read and occupancy
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = inData;
      d.wp = bump(q.wp);
    end
    if (pop) begin
      d.rp = bump(q.rp);
    end
    d.count = (PW + 1)'(q.count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
    if (flush) begin
      d.wp = '0;
      d.rp = '0;
      d.count = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // call_word_fifo

// ************************************************************
// top: status byte, call formatter and data byte
// ************************************************************
module pager_decoder_host_interface
  import pager_if_pkg::*;
#(
  parameter int WORD_GAP = WORD_GAP_CYC,
  parameter int RANGE_UNIT = RANGE_UNIT_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] busAddr,
  input wire logic busWr,
  input wire logic [7:0] busWrData,
  input wire logic busRd,
  output logic [7:0] busRdData,
  input wire logic cwValid,
  output logic cwReady,
  input wire logic [1:0] cwKind,
  input wire logic [MSG_BITS-1:0] cwBits,
  input wire logic cwErr,
  input wire logic cwSyncFail,
  input wire logic [2:0] cwAddrIdx,
  input wire logic cwDup,
  input wire logic [1:0] cwFunc,
  input wire logic formatConvEnable,
  input wire logic nibblePackSel,
  input wire logic rangeHoldSelLo,
  input wire logic rangeHoldSelHi,
  input wire logic ifEnable,
  input wire logic noSignal,
  input wire logic validTx,
  input wire logic supplyLowDet,
  input wire logic powerFailN,
  output logic coreClearN,
  output logic wordReadyFlagN
);
  typedef enum logic [1:0] {S_IDLE, S_ONE, S_EMIT} fmt_state_t;
  typedef struct packed {
    fmt_state_t st;
    logic [ACC_W-1:0] acc;
    logic [CNT_W-1:0] cnt;
    logic alpha;
    logic nibble;
    logic errq;
    logic [7:0] pend;
    logic on;
    logic res;
    logic ct;
    logic stb;
    logic bf;
    logic orf;
    logic bl;
    logic dr;
    logic [7:0] data;
    logic [7:0] rdData;
    logic [31:0] gap;
    logic [31:0] hold;
    logic cwReady;
  } top_state_t;
  // after reset: standby, core clear released, all low-active flags idle
  localparam top_state_t RESET_STATE = '{st: S_IDLE, on: 1'b1,
    res: 1'b1, stb: 1'b1, bf: 1'b1, orf: 1'b1, bl: 1'b1, dr: 1'b1,
    default: '0};
  top_state_t q, d;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [7:0] fifoInData, fifoOutData;
  logic take, run, runD, ctlWr;
  logic [CNT_W-1:0] size;
  logic [ACC_W-1:0] shifted;
  logic [6:0] blk;
  logic [31:0] limit;
  assign busRdData = q.rdData;
  assign cwReady = q.cwReady;
  assign coreClearN = q.res;
  assign wordReadyFlagN = q.dr;
  assign take = cwValid && q.cwReady;
  assign run = q.res && !q.on;
  assign ctlWr = busWr && (busAddr == CTRL_ADDR);
  assign limit = (32'({rangeHoldSelHi, rangeHoldSelLo}) + 32'h1)
                 * 32'(RANGE_UNIT);

  // block cut from the oldest unsent bits of the accumulator
  assign size = (q.alpha && !q.nibble) ? BLK_ALPHA : BLK_NUM; // RQ17
  assign shifted = q.acc >> (q.cnt - size);
  assign blk = shifted[6:0];

  call_word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(!run),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // next state of the whole block
  always_comb begin
    d = q;
    fifoInValid = 1'b0;
    fifoInData = '0;
    fifoOutReady = 1'b0;
    d.bf = powerFailN; // RQ5
    d.stb = q.on; // RQ4
    // software owns only on, clear, supply low and ready bits
    if (ctlWr) begin // RQ10
      d.on = busWrData[BIT_ON]; // RQ1
      d.res = busWrData[BIT_RES];
      d.bl = busWrData[BIT_BL]; // RQ8
      d.dr = busWrData[BIT_DR]; // RQ9
    end
    // reads only sample, so polling never disturbs a flag
    if (busRd) begin // RQ24
      if (busAddr == CTRL_ADDR) begin
        d.rdData = {q.dr, q.bl, q.orf, q.bf, q.stb, q.ct, q.res, q.on};
      end else if (busAddr == DATA_ADDR) begin
        d.rdData = q.data;
      end else begin
        d.rdData = '0;
      end
    end
    // range hold: flag falls only after the full hold has run
    if (!ifEnable || q.on || validTx) begin
      d.orf = 1'b1; // RQ7
      d.hold = '0;
    end else if (noSignal) begin
      if (q.hold >= limit) begin
        d.orf = 1'b0; // RQ6
      end else begin
        d.hold = q.hold + 32'h1;
      end
    end else begin
      d.hold = '0;
    end
    // the detector wins over a write landing in the same cycle
    if (supplyLowDet) begin
      d.bl = 1'b0; // RQ8
    end
    // paced delivery; an unread word is simply replaced by the next
    if (q.gap != '0) begin
      d.gap = q.gap - 32'h1;
    end else if (fifoOutValid) begin
      fifoOutReady = 1'b1;
      d.data = fifoOutData; // RQ12 RQ14
      d.dr = 1'b0; // RQ13 RQ9
      d.gap = 32'(WORD_GAP - 1);
    end
    // formatter
    unique case (q.st)
      S_IDLE: begin
        if (take) begin
          unique case (cw_kind_t'(cwKind))
            CW_ADDR: begin
              d.pend = {cwSyncFail, cwAddrIdx, cwDup, 1'b0, cwFunc}; // RQ23
              d.alpha = formatConvEnable && (cwFunc != FUNC_NUMERIC); // RQ17
              d.nibble = nibblePackSel;
              d.cnt = '0;
              d.ct = 1'b1; // RQ3
              d.st = S_ONE; // RQ11
            end
            CW_MSG: begin
              d.acc = {q.acc[ACC_W-MSG_BITS-1:0], cwBits};
              d.cnt = CNT_W'(q.cnt + MSG_CNT);
              d.errq = cwErr; // RQ22
              d.st = S_EMIT;
            end
            CW_END_OK: begin
              d.pend = {cwErr, TERM_WORD[6:0]}; // RQ15
              d.ct = 1'b0; // RQ3
              d.cnt = '0;
              d.st = S_ONE;
            end
            CW_END_FAIL: begin
              d.pend = {1'b1, TERM_WORD[6:0]}; // RQ16
              d.ct = 1'b0;
              d.cnt = '0;
              d.st = S_ONE;
            end
          endcase
        end
      end
      S_ONE: begin
        fifoInValid = 1'b1;
        fifoInData = q.pend;
        if (fifoInReady) begin
          d.st = S_IDLE;
        end
      end
      S_EMIT: begin
        // leftover alpha bits wait for the next codeword
        if (q.cnt < size) begin
          d.st = S_IDLE;
        end else begin
          fifoInValid = 1'b1;
          if (q.nibble) begin
            fifoInData = {q.errq, 3'h0, blk[3:0]}; // RQ20
          end else if (q.alpha) begin
            fifoInData = {q.errq, blk}; // RQ18
          end else begin
            fifoInData = {q.errq, num_to_char(blk[3:0])}; // RQ19 RQ21
          end
          if (fifoInReady) begin
            d.cnt = q.cnt - size;
          end
        end
      end
    endcase
    // held in standby or core clear: formatter stays empty
    runD = d.res && !d.on;
    if (!run) begin // RQ2
      d.st = S_IDLE;
      d.cnt = '0;
      d.ct = 1'b0;
    end
    d.cwReady = (d.st == S_IDLE) && runD;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_standby_flag: assert property ($rose(q.on) |=> q.stb ##1 q.orf) // RQ4
    else $error("standby flag or range flag did not follow standby");
  a_powerfail_follow: assert property (##1 q.bf == $past(powerFailN)) // RQ5
    else $error("power fail flag not following pin");
  a_range_hold: assert property ($fell(q.orf) |-> $past(q.hold) >= // RQ6
    $past(limit) && $past(noSignal))
    else $error("range flag fell before hold expired");
  a_range_set: assert property (validTx |=> q.orf) // RQ7
    else $error("range flag not set on valid data");
  a_supply_low: assert property (supplyLowDet |=> !q.bl) // RQ8
    else $error("supply low event lost");
  a_ready_word: assert property (fifoOutValid && fifoOutReady // RQ13
    |=> !q.dr && q.data == $past(fifoOutData) && !wordReadyFlagN)
    else $error("ready flag and data byte not together");
  a_ct_write: assert property (ctlWr && !take && run && $past(run)
    && q.st != S_IDLE |=> q.ct == $past(q.ct)) // RQ10
    else $error("write disturbed call flag");
  a_term_word: assert property (take && cwKind == CW_END_OK // RQ15
    |=> q.pend == {$past(cwErr), TERM_WORD[6:0]} && !q.ct)
    else $error("bad termination word");
  a_fail_term: assert property (take && cwKind == CW_END_FAIL // RQ16
    |=> q.pend[BIT_ERR] && q.st == S_ONE)
    else $error("failed call not flagged");
  a_addr_word: assert property (take && cwKind == CW_ADDR // RQ23
    |=> q.pend == {$past(cwSyncFail), $past(cwAddrIdx), $past(cwDup),
        1'b0, $past(cwFunc)} && fifoInValid)
    else $error("address word malformed");
  a_format_sel: assert property (take && cwKind == CW_ADDR // RQ17
    && !formatConvEnable |=> !q.alpha)
    else $error("numeric not forced with conversion off");

  c_address_taken: cover property (take && cwKind == CW_ADDR);
  c_term_sent: cover property (q.st == S_ONE && q.pend == TERM_WORD
    && fifoInReady);
  c_fifo_full: cover property (q.st == S_EMIT && !fifoInReady);
  c_range_lost: cover property ($fell(q.orf));
endmodule // pager_decoder_host_interface

// file: pager_decoder_host_interface_tb.sv
// self-checking testbench for the pager decoder host interface
`timescale 1ns/1ps
module pager_decoder_host_interface_tb;
  import pager_if_pkg::*;
  // short pacing and hold unit keep the run brief
  localparam int GAP = 16;
  localparam int UNIT = 3;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] busAddr = 8'h00;
  logic [7:0] busWrData = 8'h00;
  logic [7:0] busRdData;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic cwValid = 1'b0;
  logic cwReady;
  logic [1:0] cwKind = 2'h0;
  logic [MSG_BITS-1:0] cwBits = '0;
  logic cwErr = 1'b0;
  logic cwSyncFail = 1'b0;
  logic [2:0] cwAddrIdx = 3'h0;
  logic cwDup = 1'b0;
  logic [1:0] cwFunc = 2'h0;
  logic formatConvEnable = 1'b0;
  logic nibblePackSel = 1'b0;
  logic rangeHoldSelLo = 1'b1;
  logic rangeHoldSelHi = 1'b0;
  logic ifEnable = 1'b1;
  logic noSignal = 1'b0;
  logic validTx = 1'b0;
  logic supplyLowDet = 1'b0;
  logic powerFailN = 1'b1;
  logic coreClearN;
  logic wordReadyFlagN;
  logic [7:0] rd;
  logic [1:0] sel;
  int hold;
  logic [7:0] expQ[$];
  logic [1:0] kindQ[$];
  logic [MSG_BITS-1:0] bitsQ[$];
  logic errQ[$];
  int n_errors = 0;
  int cmp_count = 0;
  integer seed = 32'hbfa3;

  pager_decoder_host_interface #(.WORD_GAP(GAP), .RANGE_UNIT(UNIT),
    .FIFO_DEPTH(4)) dut (.mclk, .sys_rst, .busAddr, .busWr, .busWrData,
    .busRd, .busRdData, .cwValid, .cwReady, .cwKind, .cwBits, .cwErr,
    .cwSyncFail, .cwAddrIdx, .cwDup, .cwFunc, .formatConvEnable,
    .nibblePackSel, .rangeHoldSelLo, .rangeHoldSelHi, .ifEnable, .noSignal,
    .validTx, .supplyLowDet, .powerFailN, .coreClearN, .wordReadyFlagN);

  // free-running 100 MHz clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] want,
                       input string what);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH at %0t: %s saw %h want %h", $time, what, seen, want);
    end
  endtask

  // a wait that runs out ends the run
  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 3000) begin
      n_errors++;
      $display("MISMATCH at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    busAddr <= a;
    busWrData <= d;
    busWr <= 1'b1;
    @(posedge mclk);
    busWr <= 1'b0;
  endtask

  // read data is registered at the taking edge and stands until the next read
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge mclk);
    busRd <= 1'b0;
    @(posedge mclk);
    d = busRdData;
  endtask

  task automatic stat(input logic [7:0] want, input string what);
    bus_rd(CTRL_ADDR, rd);
    check(rd, want, what);
  endtask

  // hold the offer until the edge that samples ready high
  task automatic send_cw(input logic [1:0] k, input logic [MSG_BITS-1:0] b,
                         input logic e);
    int n;
    n = 0;
    @(posedge mclk);
    cwValid <= 1'b1;
    cwKind <= k;
    cwBits <= b;
    cwErr <= e;
    do tick(n); while (cwReady !== 1'b1);
    cwValid <= 1'b0;
  endtask

  // checks first edge after the previous flag write has landed
  task automatic wait_low();
    int n;
    n = 0;
    do tick(n); while (wordReadyFlagN !== 1'b0);
  endtask

  function automatic logic [6:0] num_char(input logic [3:0] n);
    case (n)
      4'ha: return 7'h2a;
      4'hb: return 7'h55;
      4'hc: return 7'h20;
      4'hd: return 7'h2d;
      4'he: return 7'h5d;
      4'hf: return 7'h5b;
      default: return {3'h3, n};
    endcase
  endfunction

  // ************************************************************
  // call builder: expected words first, then codewords
  // ************************************************************
  task automatic build_call(input int mode, input int nMsg, input bit lost);
    logic [31:0] r;
    logic [1:0] f;
    logic [6:0] blk;
    logic e;
    bit bq[$];
    r = $random(seed);
    f = (mode == 1) ? 2'h0 : r[1:0];
    if (mode == 2 && f == 2'h0) f = 2'h3;
    @(posedge mclk);
    formatConvEnable <= (mode == 3) ? r[2] : (mode != 0);
    nibblePackSel <= (mode == 3);
    cwFunc <= f;
    cwSyncFail <= r[3];
    cwAddrIdx <= r[6:4];
    cwDup <= r[7];
    expQ.push_back({r[3], r[6:4], r[7], 1'b0, f});
    kindQ.push_back(2'h0);
    bitsQ.push_back('0);
    errQ.push_back(1'b0);
    for (int m = 0; m < nMsg; m++) begin
      r = $random(seed);
      e = (mode == 2) ? 1'b0 : r[31];
      kindQ.push_back(2'h1);
      bitsQ.push_back(r[MSG_BITS-1:0]);
      errQ.push_back(e);
      if (mode == 2) begin
        for (int i = MSG_BITS - 1; i >= 0; i--) bq.push_back(r[i]);
        while (bq.size() >= 7) begin
          for (int j = 0; j < 7; j++) blk = {blk[5:0], bq.pop_front()};
          expQ.push_back({1'b0, blk});
        end
      end else begin
        for (int i = 4; i >= 0; i--) begin
          blk = (mode == 3) ? {3'h0, r[i*4+:4]} : num_char(r[i*4+:4]);
          expQ.push_back({e, blk});
        end
      end
    end
    e = lost | r[30];
    kindQ.push_back(lost ? 2'h3 : 2'h2);
    bitsQ.push_back('0);
    errQ.push_back(e);
    expQ.push_back({e, TERM_WORD[6:0]});
  endtask

  task automatic send_all();
    while (kindQ.size() > 0)
      send_cw(kindQ.pop_front(), bitsQ.pop_front(), errQ.pop_front());
  endtask

  task automatic collect();
    logic [7:0] w;
    bit first;
    first = 1'b1;
    while (expQ.size() > 0) begin
      wait_low();
      bus_rd(DATA_ADDR, w);
      check(w, expQ.pop_front(), "call word");
      // call still open, and reading the data byte left the flag low
      if (first) stat(8'h76, "call active");
      first = 1'b0;
      bus_wr(CTRL_ADDR, 8'hc2);
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    stat(8'hfb, "reset status");
    // bits 2..5 written high must not stick
    bus_wr(CTRL_ADDR, 8'hfd);
    stat(8'hf9, "core clear low");
    check({7'h0, coreClearN}, 8'h00, "core clear pin");
    bus_wr(CTRL_ADDR, 8'hc2);
    stat(8'hf2, "decoder on");
    check({7'h0, coreClearN}, 8'h01, "core clear pin");
    bus_rd(8'h20, rd);
    check(rd, 8'h00, "unmapped read");
    $display("register test done");
    powerFailN <= 1'b0;
    stat(8'he2, "power fail low");
    powerFailN <= 1'b1;
    stat(8'hf2, "power fail high");
    supplyLowDet <= 1'b1;
    @(posedge mclk);
    supplyLowDet <= 1'b0;
    stat(8'hb2, "supply low");
    bus_wr(CTRL_ADDR, 8'hc2);
    stat(8'hf2, "supply low cleared");
    $display("flag test done");
    // random hold select; hold is (sel+1)*UNIT cycles, flag survives it
    sel = 2'($random(seed));
    hold = (int'(sel) + 1) * UNIT;
    rangeHoldSelHi <= sel[1];
    rangeHoldSelLo <= sel[0];
    @(posedge mclk);
    noSignal <= 1'b1;
    repeat (hold - 1) @(posedge mclk);
    stat(8'hf2, "range hold running");
    stat(8'hd2, "range lost");
    validTx <= 1'b1;
    @(posedge mclk);
    validTx <= 1'b0;
    stat(8'hf2, "valid data");
    ifEnable <= 1'b0;
    repeat (4 * UNIT) @(posedge mclk);
    stat(8'hf2, "interface off");
    ifEnable <= 1'b1;
    repeat (hold + 2) @(posedge mclk);
    stat(8'hd2, "range lost again");
    bus_wr(CTRL_ADDR, 8'hc3);
    stat(8'hfb, "standby");
    noSignal <= 1'b0;
    bus_wr(CTRL_ADDR, 8'hc2);
    $display("range test done");
    for (int m = 0; m < 4; m++) begin
      build_call(m, 2, 1'b0);
      fork
        send_all();
        collect();
      join
      stat(8'hf2, "call ended");
      $display("call mode %0d done", m);
    end
    // unread words are overwritten; last one is the failed end
    build_call(1, 1, 1'b1);
    send_all();
    wait_low();
    repeat (8 * GAP) @(posedge mclk);
    stat(8'h72, "ready flag low");
    bus_rd(DATA_ADDR, rd);
    check(rd, 8'h84, "sync lost end");
    stat(8'h72, "read leaves flag");
    bus_wr(DATA_ADDR, 8'h55);
    bus_rd(DATA_ADDR, rd);
    check(rd, 8'h84, "data byte read only");
    expQ.delete();
    $display("overwrite test done");
    end_of_test();
  end

endmodule // pager_decoder_host_interface_tb
